// [rtl/qdl_pkg.sv]
// Purpose: shared constants and types for the quad DAC load control
// Assumes: 8-bit channel codes, four channels, 12-bit serial frame
// Notes:   frame layout is MSB first, top two bits are shutdown flags
package qdl_pkg;

  localparam int unsigned QDL_NUM_CH     = 4;
  localparam int unsigned QDL_CODE_W     = 8;
  localparam int unsigned QDL_FRAME_W    = 12;
  localparam int unsigned QDL_SYNC_W     = 2;

  // Frame field positions
  localparam int unsigned QDL_POS_SHDN_ALL = 11;
  localparam int unsigned QDL_POS_SHDN_ONE = 10;
  localparam int unsigned QDL_POS_SEL_HI   = 9;
  localparam int unsigned QDL_POS_SEL_LO   = 8;
  localparam int unsigned QDL_POS_CODE_LSB = 0;

  // Reset values
  localparam logic [7:0]  QDL_CODE_RST   = 8'h00;
  localparam logic [11:0] QDL_FRAME_RST  = 12'h000;
  localparam logic [3:0]  QDL_SHDN_RST   = 4'h0;

  typedef struct packed {
    logic       shutdown_all_bit;
    logic       shutdown_one_bit;
    logic       chan_sel_hi;
    logic       chan_sel_lo;
    logic [7:0] channel_code;
  } qdl_frame_t;

  typedef struct packed {
    logic       chan_sel_hi;
    logic       chan_sel_lo;
    logic [7:0] parallel_data_in;
  } qdl_par_t;

endpackage

// [rtl/qdl_sync.sv]
// Purpose: two-flop synchroniser for a bundle of pin levels
// Assumes: inputs are asynchronous to core_clk_i
// Notes:   first stage is read only by the second stage
`timescale 1ns/1ns
module qdl_sync #(
  parameter int unsigned WIDTH = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  // Clock and reset
  input  wire logic             core_clk_i,
  input  wire logic             rstn_i,
  // Levels
  input  wire logic [WIDTH-1:0] async_i,
  output logic      [WIDTH-1:0] sync_o
);

  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] meta_d;
  logic [WIDTH-1:0] sync_q;
  logic [WIDTH-1:0] sync_d;

  always_comb begin
    meta_d = async_i;
    sync_d = meta_q;
  end

  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      meta_q <= RST_VAL;
      sync_q <= RST_VAL;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign sync_o = sync_q;

endmodule

// [rtl/qdl_core.sv]
// Purpose: load control of a quad 8-bit DAC, serial and parallel fronts
// Assumes: all host pins are asynchronous and sampled by core_clk_i
// Notes:   latch behaviour is modelled with sampled pins; transparency
//          therefore shows after the synchroniser delay, and a clear
//          pulse shorter than one clock may be missed
`timescale 1ns/1ns

// Notes on behaviour
// - Chip select low: shift frame in MSB first on rising link clock.
// - Chip select rising with clock low copies code to addressed input reg.
// - Serial address 00,01,10,11 selects channel A,B,C,D.
// - Frame bit 11 low shuts down all four channels.
// - Frame bit 10 low shuts down only the addressed channel.
// - Serial: chip select high, load low moves all input regs to outputs.
// - Load strobe is level sensitive; outputs follow while it stays low.
// - Parallel: write low, load high passes data into addressed reg.
// - Write strobe rising edge latches the addressed input register.
// - Parallel address pins hi,lo select channel A,B,C,D.
// - Load high holds every DAC register during input writes.
// - Write high, load low: DAC registers load and stay transparent.
// - Write and load both low: data flows through to the DAC register.
// - Load rising edge with write high latches DAC registers.
// - Write and load both high: nothing changes.
// - Clear low zeroes input and DAC registers, not the shift register.
// - Chip select high ignores link clock; load works regardless of it.
module qdl_core
  import qdl_pkg::*;
#(
  parameter int unsigned NUM_CH = QDL_NUM_CH,
  parameter int unsigned CODE_W = QDL_CODE_W
) (
  // Clock and reset
  input  wire logic                           core_clk_i,
  input  wire logic                           rstn_i,
  // Variant select: high for the serial front end
  input  wire logic                           serial_mode_i,
  // Serial front end
  input  wire logic                           chip_sel_n_i,
  input  wire logic                           link_clk_i,
  input  wire logic                           serial_in_sleep_pin_i,
  // Parallel front end
  input  wire logic                           write_strobe_n_i,
  input  wire logic                           chan_sel_hi_i,
  input  wire logic                           chan_sel_lo_i,
  input  wire logic [CODE_W-1:0]              parallel_data_in_i,
  // Shared controls
  input  wire logic                           load_out_strobe_n_i,
  input  wire logic                           zero_all_n_i,
  // Channel outputs
  output logic      [NUM_CH-1:0][CODE_W-1:0]  input_reg_o,
  output logic      [NUM_CH-1:0][CODE_W-1:0]  dac_reg_o,
  output logic      [NUM_CH-1:0]              chan_shutdown_o
);

  localparam int unsigned PIN_W = 7 + CODE_W;

  // Every host pin is asynchronous, so all pass two flops first
  // Pin bundle: cs, clk, sdi, wr, hi, lo, load, data
  logic [PIN_W-1:0] pins_raw;
  logic [PIN_W-1:0] pins_s;
  logic             cs_n_s;
  logic             lclk_s;
  logic             sdi_s;
  logic             wr_n_s;
  logic             hi_s;
  logic             lo_s;
  logic             ld_n_s;
  logic [CODE_W-1:0] db_s;
  logic             clr_n_s;
  logic             mode_s;

  assign pins_raw = {chip_sel_n_i, link_clk_i, serial_in_sleep_pin_i,
                     write_strobe_n_i, chan_sel_hi_i, chan_sel_lo_i,
                     load_out_strobe_n_i, parallel_data_in_i};

  // One bundle so data and strobes see the same delay
  qdl_sync #(
    .WIDTH   (PIN_W),
    .RST_VAL ({1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1,
               {CODE_W{1'b0}}})
  ) u_pin_sync (
    .core_clk_i (core_clk_i),
    .rstn_i     (rstn_i),
    .async_i    (pins_raw),
    .sync_o     (pins_s)
  );

  qdl_sync #(
    .WIDTH   (1),
    .RST_VAL (1'b1)
  ) u_clr_sync (
    .core_clk_i (core_clk_i),
    .rstn_i     (rstn_i),
    .async_i    (zero_all_n_i),
    .sync_o     (clr_n_s)
  );

  // Front-end choice is a pin too; a raw edge could mix the fronts
  qdl_sync #(
    .WIDTH   (1),
    .RST_VAL (1'b1)
  ) u_mode_sync (
    .core_clk_i (core_clk_i),
    .rstn_i     (rstn_i),
    .async_i    (serial_mode_i),
    .sync_o     (mode_s)
  );

  assign cs_n_s = pins_s[PIN_W-1];
  assign lclk_s = pins_s[PIN_W-2];
  assign sdi_s  = pins_s[PIN_W-3];
  assign wr_n_s = pins_s[PIN_W-4];
  assign hi_s   = pins_s[PIN_W-5];
  assign lo_s   = pins_s[PIN_W-6];
  assign ld_n_s = pins_s[PIN_W-7];
  assign db_s   = pins_s[CODE_W-1:0];

  // Both fronts share one address decode
  function automatic logic [1:0] chan_index(input logic hi, input logic lo);
    chan_index = {hi, lo};
  endfunction

  // Edge history of the synchronised strobes
  // Reset values match the idle pin levels, so no false edge at start
  logic             lclk_prev_q, lclk_prev_d;
  logic             cs_prev_q, cs_prev_d;
  logic             wr_prev_q, wr_prev_d;
  logic [QDL_FRAME_W-1:0] shift_q, shift_d;
  logic [NUM_CH-1:0][CODE_W-1:0] in_q, in_d;
  logic [NUM_CH-1:0][CODE_W-1:0] dac_q, dac_d;
  logic [NUM_CH-1:0] shdn_q, shdn_d;

  qdl_frame_t frame;
  logic       lclk_rise;
  logic       cs_rise;
  logic       wr_rise;
  logic [1:0] ser_idx;
  logic [1:0] par_idx;

  // Frame fields read straight from the shift register
  assign frame     = qdl_frame_t'(shift_q);
  assign lclk_rise = lclk_s & ~lclk_prev_q;
  assign cs_rise   = cs_n_s & ~cs_prev_q;
  assign wr_rise   = wr_n_s & ~wr_prev_q;
  assign ser_idx   = chan_index(frame.chan_sel_hi, frame.chan_sel_lo);
  assign par_idx   = chan_index(hi_s, lo_s);

  always_comb begin
    lclk_prev_d = lclk_s;
    cs_prev_d   = cs_n_s;
    wr_prev_d   = wr_n_s;
    shift_d     = shift_q;
    in_d        = in_q;
    dac_d       = dac_q;
    shdn_d      = shdn_q;

    // Shift register ignores clear; cs high blocks shifting
    if (mode_s && !cs_n_s && lclk_rise) begin
      shift_d = {shift_q[QDL_FRAME_W-2:0], sdi_s};
    end

    if (mode_s) begin
      // Frame is taken only when the link clock rests low
      if (cs_rise && !lclk_s) begin
        in_d[ser_idx] = frame.channel_code;
        // Each committed frame replaces the whole shutdown state
        if (!frame.shutdown_all_bit) begin
          shdn_d = {NUM_CH{1'b1}};
        end else if (!frame.shutdown_one_bit) begin
          shdn_d = QDL_SHDN_RST;
          shdn_d[ser_idx] = 1'b1;
        end else begin
          shdn_d = QDL_SHDN_RST;
        end
      end
    end else if (!wr_n_s || wr_rise) begin
      // Low phase is transparent, rising edge keeps last sample
      in_d[par_idx] = db_s;
    end

    // Load low makes DAC regs follow input regs, high holds them.
    // Uses next input values so write-and-load-low flows straight through.
    if (!ld_n_s) begin
      dac_d = in_d;
    end else begin
      // Rising load leaves the last followed value in place
      dac_d = dac_q;
    end

    // Clear comes last so it beats a write, or a commit's code but not its shutdown bits, in the same cycle
    if (!clr_n_s) begin
      in_d   = '0;
      dac_d  = '0;
    end
  end

  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      lclk_prev_q <= 1'b0;
      cs_prev_q   <= 1'b1;
      wr_prev_q   <= 1'b1;
      shift_q     <= QDL_FRAME_RST;
      in_q        <= '0;
      dac_q       <= '0;
      shdn_q      <= QDL_SHDN_RST;
    end else begin
      lclk_prev_q <= lclk_prev_d;
      cs_prev_q   <= cs_prev_d;
      wr_prev_q   <= wr_prev_d;
      shift_q     <= shift_d;
      in_q        <= in_d;
      dac_q       <= dac_d;
      shdn_q      <= shdn_d;
    end
  end

  // Outputs straight from flops, no decode after them
  assign input_reg_o     = in_q;
  assign dac_reg_o       = dac_q;
  assign chan_shutdown_o = shdn_q;

endmodule

// [verif/qdl_host_model.sv]
// Purpose: serial host that clocks frames into the load control
// Assumes: link clock is 800 ns and stands low between frames
// Notes:   a released data line shows the inverse of its last bit
`timescale 1ns/1ns
module qdl_host_model (
  // Serial link
  output logic cs_n_o,
  output logic sclk_o,
  output logic sdi_o
);
  initial begin
    cs_n_o = 1'b1;
    sclk_o = 1'b0;
    sdi_o  = 1'b0;
  end
  // Extra leading bits must fall out of the shift register; with clk_hi
  // select rises while the clock is high, so no commit may follow
  task automatic send(input logic [11:0] f, input int extra,
                      input bit clk_hi);
    cs_n_o = 1'b0; // Select before the first edge
    for (int i = 0; i < extra + 12; i++) begin
      sdi_o = i < extra ? i[0] : f[11 + extra - i]; // MSB first
      #400 sclk_o = 1'b1;
      if (!clk_hi || i < extra + 11)
        #400 sclk_o = 1'b0;
    end
    #400 cs_n_o = 1'b1; // Rises with clock low unless refused
    sdi_o = ~sdi_o;
    if (clk_hi)
      #400 sclk_o = 1'b0;
  endtask
endmodule

// [verif/qdl_core_monitor.sv]
// Purpose: pin-level relations of the quad DAC load control
// Assumes: pins pass a two-flop sync, so levels held 5 cycles settle
// Notes:   exact latencies are left to the bench scoreboard
`timescale 1ns/1ns
module qdl_core_monitor (
  // Clock and reset
  input wire logic            core_clk_i,
  input wire logic            rstn_i,
  // Host pins
  input wire logic            serial_mode_i,
  input wire logic            chip_sel_n_i,
  input wire logic            write_strobe_n_i,
  input wire logic            chan_sel_hi_i,
  input wire logic            chan_sel_lo_i,
  input wire logic [7:0]      parallel_data_in_i,
  input wire logic            load_out_strobe_n_i,
  input wire logic            zero_all_n_i,
  // Outputs
  input wire logic [3:0][7:0] input_reg_o,
  input wire logic [3:0][7:0] dac_reg_o,
  input wire logic [3:0]      chan_shutdown_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rstn_i);
  logic clr, ld, hold, sidle, sbusy, pidle, pwr;
  logic [1:0]  sel;
  logic [9:0]  pkey;
  logic [35:0] regs;
  assign clr   = !zero_all_n_i;
  assign ld    = !load_out_strobe_n_i && zero_all_n_i;
  assign hold  = load_out_strobe_n_i && zero_all_n_i;
  assign sidle = serial_mode_i && chip_sel_n_i && zero_all_n_i;
  assign sbusy = serial_mode_i && !chip_sel_n_i && zero_all_n_i;
  assign pidle = !serial_mode_i && write_strobe_n_i && zero_all_n_i;
  assign pwr   = !serial_mode_i && !write_strobe_n_i && zero_all_n_i;
  assign sel   = {chan_sel_hi_i, chan_sel_lo_i};
  assign pkey  = {sel, parallel_data_in_i};
  assign regs  = {input_reg_o, chan_shutdown_o};
  property p_clear; clr[*5] |-> (input_reg_o | dac_reg_o) == '0; endproperty
  a_clear: assert property (p_clear) else $error("clear failed");
  property p_follow; ld[*5] |-> dac_reg_o == input_reg_o; endproperty
  a_follow: assert property (p_follow) else $error("no follow");
  property p_hold; hold[*5] |=> $stable(dac_reg_o); endproperty
  a_hold: assert property (p_hold) else $error("dac moved");
  property p_sidle; sidle[*5] |=> $stable(regs); endproperty
  a_sidle: assert property (p_sidle) else $error("idle change");
  property p_sbusy; sbusy[*5] |=> $stable(input_reg_o); endproperty
  a_sbusy: assert property (p_sbusy) else $error("shift leaked");
  property p_pidle; pidle[*5] |=> $stable(input_reg_o); endproperty
  a_pidle: assert property (p_pidle) else $error("input moved");
  property p_track;
    (pwr && $stable(pkey))[*5] |-> input_reg_o[sel] == pkey[7:0]; endproperty
  a_track: assert property (p_track) else $error("no track");
  property p_psd; (!serial_mode_i)[*5] |=> $stable(regs[3:0]); endproperty
  a_psd: assert property (p_psd) else $error("shutdown moved");
endmodule
bind qdl_core qdl_core_monitor qdl_core_monitor_i (.*);

// [verif/testbench.sv]
// Purpose: self-checking bench for the quad DAC load control
// Assumes: serial frames come from the host model
// Notes:   each output change is matched in order against queued notes
`timescale 1ns/1ns
module testbench;
  logic clk = 1'b0, rst_n = 1'b0, mode = 1'b1, wr_n = 1'b0, hi = 1'b0;
  logic lo = 1'b0, ld_n = 1'b1, clr_n = 1'b1, ld_low = 1'b0;
  logic cs_n, sclk, sdi;
  logic [7:0] pdata = 8'h00;
  logic [3:0][7:0] in_o, dac_o, e_in = '0, e_dac = '0;
  logic [3:0] sd_o, e_sd = 4'h0;
  logic [67:0] q[$], last_n = '0, prev = '0, cur;
  logic [31:0] seed = 32'h45;
  int fail_count = 0, tests_run = 0;
  qdl_host_model qdl_host_model_i (.cs_n_o(cs_n), .sclk_o(sclk), .sdi_o(sdi));
  qdl_core qdl_core_i (
    .core_clk_i(clk), .rstn_i(rst_n), .serial_mode_i(mode),
    .chip_sel_n_i(cs_n), .link_clk_i(sclk), .serial_in_sleep_pin_i(sdi),
    .write_strobe_n_i(wr_n), .chan_sel_hi_i(hi), .chan_sel_lo_i(lo),
    .parallel_data_in_i(pdata), .load_out_strobe_n_i(ld_n),
    .zero_all_n_i(clr_n), .input_reg_o(in_o), .dac_reg_o(dac_o),
    .chan_shutdown_o(sd_o));
  initial forever #50 clk = ~clk;
  function automatic logic [7:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction
  task automatic check(input string nm, input logic [67:0] s, e);
    tests_run++;
    if (s !== e) begin
      fail_count++;
      $display("unexpected %s: expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic report_and_stop();
    if (fail_count == 0 && tests_run > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // Only real changes are noted, since equal values show no event
  task automatic note();
    logic [67:0] v;
    if (ld_low)
      e_dac = e_in;
    v = {e_in, e_dac, e_sd};
    if (v !== last_n)
      q.push_back(v);
    last_n = v;
  endtask
  task automatic frame(input logic [1:0] fl, ch, input int extra);
    logic [7:0] c;
    c = rnd();
    e_in[ch] = c;
    e_sd = !fl[1] ? 4'hF : !fl[0] ? 4'h1 << ch : 4'h0;
    note();
    qdl_host_model_i.send({fl, ch, c}, extra, 1'b0);
    repeat (5) @(negedge clk);
  endtask
  task automatic pwrite(input logic [1:0] ch);
    logic [7:0] c;
    c = rnd();
    @(negedge clk);
    {hi, lo} = ch;
    pdata = c;
    @(negedge clk);
    wr_n = 1'b0;
    e_in[ch] = c;
    note();
    repeat (6) @(negedge clk);
    wr_n = 1'b1;
    repeat (4) @(negedge clk);
  endtask
  task automatic load(input logic lv);
    @(negedge clk);
    ld_n = lv;
    ld_low = !lv;
    note();
    repeat (6) @(negedge clk);
  endtask
  // Flops have settled by the falling edge
  always @(negedge clk) begin
    cur = {in_o, dac_o, sd_o};
    if (rst_n && cur !== prev) begin
      if (q.size() == 0)
        check("spurious", cur, prev);
      else
        check("out", cur, q.pop_front());
    end
    prev = cur;
  end
  initial begin
    repeat (16) @(negedge clk);
    rst_n = 1'b1;
    repeat (3) @(negedge clk);
    pdata = rnd(); // Parallel pins wiggle in serial mode
    for (int i = 0; i < 4; i++)
      frame({i != 2, i != 1}, i[1:0], i);
    // Select rising with the link clock high must not commit
    qdl_host_model_i.send(12'hC5A, 0, 1'b1);
    repeat (5) @(negedge clk);
    load(1'b0);
    frame(2'b11, 2'd0, 0);
    load(1'b1);
    e_in = '0;
    e_dac = '0;
    note();
    fork
      frame(2'b11, 2'd2, 0);
      begin
        #2100 clr_n = 1'b0;
        #600 clr_n = 1'b1;
      end
    join
    wr_n = 1'b1;
    repeat (4) @(negedge clk);
    mode = 1'b0;
    repeat (4) @(negedge clk);
    for (int i = 0; i < 4; i++)
      pwrite(i[1:0]);
    load(1'b0);
    pwrite(2'd3);
    load(1'b1);
    pwrite(2'd1);
    for (int i = 0; i < 50 && q.size() > 0; i++)
      @(negedge clk);
    if (q.size() > 0)
      fail_count++;
    report_and_stop();
  end
endmodule
